// [hw/mrx_decode.sv]
// instruction word classifier for the execute block
`timescale 1ns/100ps
module mrx_decode (
    input  wire logic [mrx_pkg::OP_W-1:0] instr,   // fetched instruction word
    output mrx_pkg::mrx_op_e              op_kind  // decoded operation
);
    import mrx_pkg::*;

    // pure combinational match, priority on full-word forms first
    always_comb begin
        if (instr == OPC_NOP)
            op_kind = MRX_NOP;
        else if (instr == OPC_IRQ_RET)
            op_kind = MRX_IRET;
        else if (instr[OP_W-1 -: $bits(OPC_COPY_FILE)] == OPC_COPY_FILE)
            op_kind = MRX_COPY;
        else if (instr[OP_W-1 -: $bits(OPC_ROT_LEFT)] == OPC_ROT_LEFT)
            op_kind = MRX_ROTL;
        else if (instr[OP_W-1 -: $bits(OPC_STORE_ACC)] == OPC_STORE_ACC)
            op_kind = MRX_STORE;
        else if (instr[OP_W-1 -: $bits(OPC_LOAD_LIT)] == OPC_LOAD_LIT)
            op_kind = MRX_LOADL;
        else if (instr[OP_W-1 -: $bits(OPC_RET_LIT)] == OPC_RET_LIT)
            op_kind = MRX_RETL;
        else
            op_kind = MRX_NONE;
    end
endmodule

// [hw/mrx_exec.sv]
// execute stage for move, literal, return, rotate and no-op instructions
`timescale 1ns/100ps
// every answer appears one clock after the word is taken; a return adds a
// second cycle in which the next word is refused, and a flush pulse after it
// so the fetch side can discard what it prefetched
module mrx_exec (
    input  wire logic                           mclk,          // core instruction clock
    input  wire logic                           arst_n,        // async reset, active low
    input  wire logic                           instr_valid,   // instr holds a word this cycle
    input  wire logic [mrx_pkg::OP_W-1:0]       instr,         // fetched instruction word
    input  wire logic [mrx_pkg::DATA_W-1:0]     file_rdata,    // addressed file register value
    input  wire logic [mrx_pkg::PC_W-1:0]       stack_head,    // saved return address
    input  wire mrx_pkg::mrx_flags_s            flags_in,      // current zero and carry
    output mrx_pkg::mrx_fwr_s                   file_wr,       // file register write request
    output logic [mrx_pkg::DATA_W-1:0]          main_operand_reg, // working accumulator
    output mrx_pkg::mrx_flags_s                 flags_out,     // flag values to commit
    output logic                                zero_we,       // commit result_null_flag
    output logic                                carry_we,      // commit rollover_bit
    output logic                                stack_pop,     // pop return stack, pulse
    output logic                                pc_load,       // load pc from pc_value, pulse
    output logic [mrx_pkg::PC_W-1:0]            pc_value,      // target for pc_load
    output logic                                pc_advance,    // normal pc increment, pulse
    output logic                                master_irq_allow_set, // set master_irq_allow
    output logic                                flush,         // discard fetched word, pulse
    output logic                                busy           // second cycle of a return
);
    import mrx_pkg::*;

    // decoder result for the word on instr this cycle
    mrx_op_e              op_kind;          // decoded class of instr

    // sequencing: a return keeps the block for one more cycle
    mrx_state_e           state_reg, state_next;   // exec or flush cycle

    // results that persist until the next writer
    logic [DATA_W-1:0]    acc_reg, acc_next;       // working accumulator
    logic [PC_W-1:0]      pcv_reg, pcv_next;       // last return target

    // one-cycle requests towards file, flags, stack and pc
    mrx_fwr_s             fwr_reg, fwr_next;       // file write request
    mrx_flags_s           flg_reg, flg_next;       // flag values to commit
    logic                 zwe_reg, zwe_next;       // zero flag commit
    logic                 cwe_reg, cwe_next;       // carry flag commit
    logic                 pop_reg, pop_next;       // stack pop
    logic                 pcl_reg, pcl_next;       // pc load from target

    // one-cycle sequencing pulses towards fetch and interrupt logic
    logic                 adv_reg, adv_next;       // plain pc increment
    logic                 irq_reg, irq_next;       // interrupt enable set
    logic                 fl_reg, fl_next;         // drop fetched word
    logic                 busy_reg, busy_next;     // return second cycle

    // operand fields and datapath helpers
    logic [DATA_W-1:0]    rot_val;          // rotated file value
    logic                 dest_file;        // destination select bit
    logic [ADDR_W-1:0]    faddr;            // file operand

    // classify the word; unknown words come back as MRX_NONE and do nothing
    mrx_decode u_dec (
        .instr   (instr),
        .op_kind (op_kind)
    );

    // operand fields; file_rdata already belongs to faddr in this cycle
    assign dest_file = instr[DEST_BIT];
    assign faddr     = instr[ADDR_W-1:0];
    // old bit 7 leaves for the carry, old carry enters bit 0
    assign rot_val   = {file_rdata[MSB-1:0], flags_in.carry};

    // next-state and pulse generation; every pulse defaults low so it lasts one cycle
    // flags echo flags_in by default, so a flag whose enable stays low is only
    // rewritten with its own value; the core may ignore flags_out without it
    always_comb begin
        // hold levels, drop pulses
        state_next = state_reg;
        acc_next   = acc_reg;
        fwr_next   = '0;
        flg_next   = flags_in;
        zwe_next   = 1'b0;
        cwe_next   = 1'b0;
        pop_next   = 1'b0;
        pcl_next   = 1'b0;
        pcv_next   = pcv_reg;
        adv_next   = 1'b0;
        irq_next   = 1'b0;
        fl_next    = 1'b0;
        busy_next  = 1'b0;

        // exec takes words, flush covers the second cycle of a return
        unique case (state_reg)
            MRX_EXEC: begin
                // an empty slot leaves every pulse low and the pc untouched
                if (instr_valid) begin
                    unique case (op_kind)
                        // no-operation: only the pc moves on
                        MRX_NOP: begin
                            adv_next = 1'b1;
                        end
                        // copy: the moved value drives the zero flag for either destination
                        MRX_COPY: begin
                            if (dest_file) begin
                                fwr_next = '{we: 1'b1, addr: faddr, data: file_rdata};
                            end else begin
                                acc_next = file_rdata;
                            end
                            // rewriting a register onto itself is the cheap zero test
                            flg_next.zero = (file_rdata == '0);
                            zwe_next      = 1'b1;
                            adv_next      = 1'b1;
                        end
                        // literal load: no flag enable is raised
                        MRX_LOADL: begin
                            acc_next = instr[DATA_W-1:0];
                            adv_next = 1'b1;
                        end
                        // store: writes the accumulator as it stood before this word
                        MRX_STORE: begin
                            fwr_next = '{we: 1'b1, addr: faddr, data: acc_reg};
                            adv_next = 1'b1;
                        end
                        // literal return: first cycle pops the stack and loads the pc;
                        // stack_head is captured now because the pop changes it, and
                        // busy marks the cycle in which the next word is refused
                        MRX_RETL: begin
                            acc_next   = instr[DATA_W-1:0];
                            pop_next   = 1'b1;
                            pcl_next   = 1'b1;
                            pcv_next   = stack_head;
                            busy_next  = 1'b1;
                            state_next = MRX_FLUSH;
                        end
                        // interrupt return: as the literal return, accumulator untouched,
                        // plus a one-cycle request to set master_irq_allow; the enable
                        // itself lives in the interrupt logic, not here
                        MRX_IRET: begin
                            pop_next   = 1'b1;
                            pcl_next   = 1'b1;
                            pcv_next   = stack_head;
                            irq_next   = 1'b1;
                            busy_next  = 1'b1;
                            state_next = MRX_FLUSH;
                        end
                        // rotate left through carry: only the carry enable is raised,
                        // the zero flag is left alone even for a zero result
                        MRX_ROTL: begin
                            if (dest_file) begin
                                fwr_next = '{we: 1'b1, addr: faddr, data: rot_val};
                            end else begin
                                acc_next = rot_val;
                            end
                            flg_next.carry = file_rdata[MSB];
                            cwe_next       = 1'b1;
                            adv_next       = 1'b1;
                        end
                        MRX_NONE: begin
                            // other instructions belong to other execute units;
                            // no pulse and no pc step, their own unit answers
                        end
                    endcase
                end
            end
            MRX_FLUSH: begin
                // second cycle: the word fetched behind the return is dropped
                // instr_valid is not looked at here, so a prefetched word
                // never reaches the file, the accumulator or the flags
                fl_next    = 1'b1;
                state_next = MRX_EXEC;
            end
        endcase
    end

    // registers only; outputs come straight from these flops
    // asynchronous reset keeps every request low before the first clock
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            // reset: all pulses low, accumulator and pc target at reset values
            state_reg <= MRX_EXEC;
            acc_reg   <= ACC_RST;
            fwr_reg   <= '0;
            flg_reg   <= '0;
            zwe_reg   <= 1'b0;
            cwe_reg   <= 1'b0;
            pop_reg   <= 1'b0;
            pcl_reg   <= 1'b0;
            pcv_reg   <= PC_RST;
            adv_reg   <= 1'b0;
            irq_reg   <= 1'b0;
            fl_reg    <= 1'b0;
            busy_reg  <= 1'b0;
        end else begin
            // plain register copy of the next values
            state_reg <= state_next;
            acc_reg   <= acc_next;
            fwr_reg   <= fwr_next;
            flg_reg   <= flg_next;
            zwe_reg   <= zwe_next;
            cwe_reg   <= cwe_next;
            pop_reg   <= pop_next;
            pcl_reg   <= pcl_next;
            pcv_reg   <= pcv_next;
            adv_reg   <= adv_next;
            irq_reg   <= irq_next;
            fl_reg    <= fl_next;
            busy_reg  <= busy_next;
        end
    end

    // every output is a flop; nothing combinational reaches a port, which costs
    // one cycle of latency but keeps the core's timing paths short
    assign main_operand_reg     = acc_reg;
    // file and flag requests
    assign file_wr              = fwr_reg;
    assign flags_out            = flg_reg;
    assign zero_we              = zwe_reg;
    assign carry_we             = cwe_reg;
    // stack, pc and sequencing pulses
    assign stack_pop            = pop_reg;
    assign pc_load              = pcl_reg;
    assign pc_value             = pcv_reg;
    assign pc_advance           = adv_reg;
    assign master_irq_allow_set = irq_reg;
    assign flush                = fl_reg;
    assign busy                 = busy_reg;
endmodule

// [shared/mrx_pkg.sv]
// shared constants and types for the move/return/rotate execute block
// Summary of operation
// - copy_file_reg moves file to accumulator or back
// - copy_file_reg sets zero flag from value
// - load_literal_acc loads literal, flags unchanged
// - store_acc_to_file writes accumulator to file
// - return_with_literal loads literal into accumulator
// - return_with_literal pops stack_head into PC
// - return_with_literal takes two cycles, flushes fetch
// - rotate_left_carry rotates through rollover_bit only
// - rotate_left_carry result to accumulator or file
package mrx_pkg;
    localparam int DATA_W = 8;                  // data path width
    localparam int ADDR_W = 7;                  // file address width
    localparam int PC_W   = 13;                 // program counter width
    localparam int OP_W   = 14;                 // instruction word width
    localparam int MSB    = 7;                  // top data bit position
    localparam int DEST_BIT = 7;                // destination select bit in word

    // opcode patterns, upper six bits for copy and rotate, seven for store, four for literal forms
    localparam logic [5:0] OPC_COPY_FILE = 6'h08;   // copy_file_reg
    localparam logic [5:0] OPC_ROT_LEFT  = 6'h0D;   // rotate_left_carry
    localparam logic [6:0] OPC_STORE_ACC = 7'h01;   // store_acc_to_file, top seven bits
    localparam logic [3:0] OPC_LOAD_LIT  = 4'hC;    // load_literal_acc, top four bits
    localparam logic [3:0] OPC_RET_LIT   = 4'hD;    // return_with_literal, top four bits
    localparam logic [13:0] OPC_IRQ_RET  = 14'h0009; // interrupt_return, full word
    localparam logic [13:0] OPC_NOP      = 14'h0000; // no-operation, full word

    localparam logic [7:0]  ACC_RST = 8'h00;     // accumulator reset value
    localparam logic [12:0] PC_RST  = 13'h0000;  // program counter reset value

    typedef enum logic [2:0] {
        MRX_NONE, MRX_NOP, MRX_COPY, MRX_LOADL, MRX_STORE, MRX_RETL, MRX_IRET, MRX_ROTL
    } mrx_op_e;

    typedef enum {MRX_EXEC, MRX_FLUSH} mrx_state_e;

    // file register write request
    typedef struct packed {
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } mrx_fwr_s;

    // status flags as this block sees them
    typedef struct packed {
        logic zero;
        logic carry;
    } mrx_flags_s;
endpackage

// [tb/mrx_exec_monitor.sv]
// port-level assertion checker for the execute block
`timescale 1ns/100ps
module mrx_exec_monitor (
    input wire logic                       mclk,     // clock
    input wire logic                       arst_n,   // reset, active low
    input wire logic                       instr_valid, // word strobe
    input wire logic [mrx_pkg::OP_W-1:0]   instr,    // word
    input wire logic [mrx_pkg::DATA_W-1:0] file_rdata, // file value
    input wire logic [mrx_pkg::PC_W-1:0]   stack_head, // return address
    input wire mrx_pkg::mrx_flags_s        flags_in, // flags in
    input wire mrx_pkg::mrx_fwr_s          file_wr,  // write request
    input wire logic [mrx_pkg::DATA_W-1:0] main_operand_reg, // accumulator
    input wire mrx_pkg::mrx_flags_s        flags_out, // flags out
    input wire logic                       zero_we,  // zero commit
    input wire logic                       carry_we, // carry commit
    input wire logic                       stack_pop, // pop pulse
    input wire logic                       pc_load,  // pc load pulse
    input wire logic [mrx_pkg::PC_W-1:0]   pc_value, // pc target
    input wire logic                       pc_advance, // pc step
    input wire logic                       master_irq_allow_set, // irq enable set
    input wire logic                       flush,    // flush pulse
    input wire logic                       busy      // return second cycle
);
    import mrx_pkg::*;
    // the busy cycle is left out: the word there is discarded
    logic tk, cp, rt, ld, st, rl, ir, np;
    assign tk = instr_valid && !busy;
    assign cp = tk && instr[13:8] == OPC_COPY_FILE;
    assign rt = tk && instr[13:8] == OPC_ROT_LEFT;
    assign st = tk && instr[13:7] == OPC_STORE_ACC;
    assign ld = tk && instr[13:10] == OPC_LOAD_LIT;
    assign rl = tk && instr[13:10] == OPC_RET_LIT;
    assign ir = tk && instr == OPC_IRQ_RET;
    assign np = tk && instr == OPC_NOP;
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    a_copy_dest: assert property (cp |=> ($past(instr[7]) ? file_wr.we &&
        file_wr.data == $past(file_rdata) : main_operand_reg == $past(file_rdata)))
        else $error("copy destination wrong");
    a_copy_zero: assert property (cp |=> zero_we && !carry_we &&
        flags_out.zero == ($past(file_rdata) == 8'h00)) else $error("copy zero flag wrong");
    a_load_lit: assert property (ld |=> main_operand_reg == $past(instr[7:0])
        && !zero_we && !carry_we && !file_wr.we) else $error("literal load wrong");
    a_store_acc: assert property (st |=> file_wr.we && file_wr.addr == $past(instr[6:0])
        && file_wr.data == $past(main_operand_reg) && !zero_we) else $error("store wrong");
    a_retl_pop: assert property (rl |=> stack_pop && pc_load &&
        pc_value == $past(stack_head) && main_operand_reg == $past(instr[7:0]) && !zero_we)
        else $error("literal return wrong");
    a_ret_flush: assert property ((rl || ir) |=> busy && !pc_advance ##1
        flush && !stack_pop && !busy) else $error("return flush wrong");
    a_rot_carry: assert property (rt |=> carry_we && !zero_we &&
        flags_out.carry == $past(file_rdata[7])) else $error("rotate carry wrong");
    a_rot_dest: assert property (rt |=> ($past(instr[7]) ? file_wr.data ==
        {$past(file_rdata[6:0]), $past(flags_in.carry)} : main_operand_reg ==
        {$past(file_rdata[6:0]), $past(flags_in.carry)})) else $error("rotate result wrong");
    a_nop_quiet: assert property (np |=> pc_advance && !file_wr.we && !zero_we &&
        !carry_we && !stack_pop && $stable(main_operand_reg)) else $error("nop not quiet");
    a_iret_enable: assert property (ir |=> master_irq_allow_set && stack_pop &&
        pc_value == $past(stack_head) && $stable(main_operand_reg) && !zero_we && !carry_we)
        else $error("irq return wrong");
endmodule

bind mrx_exec mrx_exec_monitor u_mon (
    .mclk                 (mclk),
    .arst_n               (arst_n),
    .instr_valid          (instr_valid),
    .instr                (instr),
    .file_rdata           (file_rdata),
    .stack_head           (stack_head),
    .flags_in             (flags_in),
    .file_wr              (file_wr),
    .main_operand_reg     (main_operand_reg),
    .flags_out            (flags_out),
    .zero_we              (zero_we),
    .carry_we             (carry_we),
    .stack_pop            (stack_pop),
    .pc_load              (pc_load),
    .pc_value             (pc_value),
    .pc_advance           (pc_advance),
    .master_irq_allow_set (master_irq_allow_set),
    .flush                (flush),
    .busy                 (busy)
);

// [tb/mrx_exec_tb.sv]
// self-checking bench for the execute block
`timescale 1ns/100ps
module mrx_exec_tb;
    import mrx_pkg::*;
    logic                mclk = 1'b0;    // core clock
    logic                arst_n = 1'b0;  // reset, active low
    logic                vld = 1'b0;     // word strobe
    logic [OP_W-1:0]     instr = OPC_NOP; // word
    logic [DATA_W-1:0]   frd = 8'h00;    // file value
    logic [PC_W-1:0]     sh = 13'h0000;  // return address
    mrx_flags_s          fin = 2'h0;     // flags in
    mrx_fwr_s            fwr;            // write request
    mrx_flags_s          fout;           // flags out
    logic [DATA_W-1:0]   acc;            // accumulator
    logic [PC_W-1:0]     pcv;            // pc target
    logic zwe, cwe, pop, pcl, adv, irq, fl, bsy; // pulses
    int fail_count = 0, total_checks = 0, cyc = 0;
    mrx_exec DUT (.mclk(mclk), .arst_n(arst_n), .instr_valid(vld), .instr(instr),
        .file_rdata(frd), .stack_head(sh), .flags_in(fin), .file_wr(fwr),
        .main_operand_reg(acc), .flags_out(fout), .zero_we(zwe), .carry_we(cwe),
        .stack_pop(pop), .pc_load(pcl), .pc_value(pcv), .pc_advance(adv),
        .master_irq_allow_set(irq), .flush(fl), .busy(bsy));
    always #5 mclk = ~mclk;
    // hang guard, far above the run length
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 1000) begin
            fail_count++;
            results;
        end
    end
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [15:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one word for one cycle; outputs are settled on return
    task automatic issue(input logic [13:0] w, input logic [7:0] v);
        @(posedge mclk);
        #1 vld = 1'b1;
        instr = w;
        frd = v;
        @(posedge mclk);
        #1 vld = 1'b0;
    endtask
    task automatic t_load_store;
        issue({OPC_LOAD_LIT, 2'h3, 8'hFF}, 8'h00);
        check("acc", acc, 16'h00FF);
        check("flag_we", {zwe, cwe}, 16'h0000);
        issue({OPC_STORE_ACC, 7'h7F}, 8'h00);
        check("store", fwr, {1'b1, 7'h7F, 8'hFF});
        check("flag_we", {zwe, cwe}, 16'h0000);
    endtask
    // both destinations, zero and non-zero values
    task automatic t_copy;
        for (int i = 0; i < 4; i++) begin
            issue({OPC_COPY_FILE, i[0], 7'h05}, i[1] ? 8'hA5 : 8'h00);
            if (i[0]) check("copy_wr", fwr, {1'b1, 7'h05, i[1] ? 8'hA5 : 8'h00});
            else check("copy_acc", acc, i[1] ? 16'h00A5 : 16'h0000);
            check("zero", {zwe, cwe, fout.zero}, {13'h0, 2'h2, !i[1]});
        end
    endtask
    task automatic t_rot;
        fin = 2'h1;
        issue({OPC_ROT_LEFT, 1'b0, 7'h10}, 8'h80);
        check("rot_acc", acc, 16'h0001);
        check("rot_c", {zwe, cwe, fout.carry}, 16'h0003);
        fin = 2'h2;
        issue({OPC_ROT_LEFT, 1'b1, 7'h10}, 8'h7F);
        check("rot_wr", fwr, {1'b1, 7'h10, 8'hFE});
        check("rot_c", {zwe, cwe, fout.carry}, 16'h0002);
    endtask
    task automatic t_nop;
        issue(OPC_NOP, 8'h00);
        check("nop", {fwr.we, zwe, cwe, pop, adv}, 16'h0001);
        check("nop_acc", acc, 16'h0001);
    endtask
    // a word offered in the busy cycle must be discarded
    task automatic t_ret;
        for (int i = 0; i < 2; i++) begin
            @(posedge mclk);
            #1 vld = 1'b1;
            sh = i ? 13'h1FFF : 13'h0ABC;
            instr = i ? OPC_IRQ_RET : {OPC_RET_LIT, 2'h0, 8'h5A};
            @(posedge mclk);
            #1 instr = {OPC_LOAD_LIT, 2'h0, 8'h33};
            check("ret", {bsy, pop, pcl, irq, adv}, {11'h0, 3'h7, i[0], 1'b0});
            check("pc", pcv, sh);
            check("acc", acc, 16'h005A);
            @(posedge mclk);
            #1 vld = 1'b0;
            check("flush", {fl, pop, bsy}, 16'h0004);
            check("acc", acc, 16'h005A);
        end
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        #1 arst_n = 1'b1;
        t_load_store;
        t_copy;
        t_rot;
        t_nop;
        t_ret;
        results;
    end
endmodule
